// ==== verilog/hwcfg_pkg.sv ====
// package of offsets, field positions and reset values for the hardware configuration bank
package hwcfg_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned NUM_REGS = 6;
  // register offsets
  localparam logic [7:0] OFF_HW_PIN_SETUP         = 8'hA4;
  localparam logic [7:0] OFF_DEVICE_SETUP_ONE     = 8'hA6;
  localparam logic [7:0] OFF_DEVICE_SETUP_TWO     = 8'hA8;
  localparam logic [7:0] OFF_PERIPHERAL_SETUP_ONE = 8'hAA;
  localparam logic [7:0] OFF_GATE_DRIVE_SETUP_ONE = 8'hAC;
  localparam logic [7:0] OFF_GATE_DRIVE_SETUP_TWO = 8'hAE;
  // register indices
  localparam int unsigned IDX_PIN  = 0;
  localparam int unsigned IDX_DEV1 = 1;
  localparam int unsigned IDX_DEV2 = 2;
  // reset values
  localparam logic [31:0] RST_HW_PIN_SETUP     = 32'h00000000;
  localparam logic [31:0] RST_DEVICE_SETUP_TWO = 32'h00000000;
  localparam logic [31:0] RST_OTHER            = 32'h00000000;
  // device setup one: bits reset to zero; others take strap values
  localparam logic [31:0] DEV1_ZERO_MASK       = 32'hF800001F;
  // field positions in hw_pin_setup, bus voltage in device setup one
  localparam int unsigned PIN_SPEED_LSB  = 0;
  localparam int unsigned PIN_BRAKE_LSB  = 2;
  localparam int unsigned PIN_ANGLE_BIT  = 4;
  localparam int unsigned PIN_STYLE_BIT  = 5;
  localparam int unsigned PARITY_BIT     = 31;
  localparam int unsigned BUSV_LSB       = 0;
  // speed source codes
  localparam logic [1:0] SPD_ANALOG = 2'h0;
  localparam logic [1:0] SPD_DUTY   = 2'h1;
  localparam logic [1:0] SPD_REG    = 2'h2;
  localparam logic [1:0] SPD_FREQ   = 2'h3;
  // brake override codes
  localparam logic [1:0] BRK_FORCE_ON  = 2'h1;
  localparam logic [1:0] BRK_FORCE_OFF = 2'h2;
  // maximum bus voltage codes
  localparam logic [1:0] BUSV_15 = 2'h0;
  localparam logic [1:0] BUSV_30 = 2'h1;
  localparam logic [1:0] BUSV_60 = 2'h2;
  // states of the brake sequencer
  typedef enum logic [2:0] {
    HWCFG_RUN       = 3'b001,
    HWCFG_LOW_BRAKE = 3'b010,
    HWCFG_ALIGN     = 3'b100
  } hwcfg_brake_t;
endpackage : hwcfg_pkg

// ==== verilog/hwcfg_word.sv ====
// one 32-bit configuration word with per-bit reset values
`timescale 1ns/1ns
module hwcfg_word #(
  parameter logic [31:0] RST_MASK = 32'hFFFFFFFF,
  parameter logic [31:0] RST_VAL  = 32'h00000000
) (
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        clk_en,
  input  wire logic        wr_en,
  input  wire logic [31:0] wr_data,
  input  wire logic        strap_load,
  input  wire logic [31:0] strap_val,
  output logic [31:0]      q_r
);
  logic [31:0] q_nxt;
  genvar b;
  // per bit next value: a write wins over the strap capture
  generate
    for (b = 0; b < 32; b = b + 1) begin : g_bit
      if (RST_MASK[b]) begin : g_fixed
        assign q_nxt[b] = wr_en ? wr_data[b] : q_r[b];
      end else begin : g_strap
        // strap sampled by clock after release, never in reset
        assign q_nxt[b] = wr_en ? wr_data[b] : (strap_load ? strap_val[b] : q_r[b]);
      end
    end
  endgenerate

  // one process owns the whole word; strap bits sit at zero until the load pulse
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      q_r <= RST_VAL & RST_MASK;
    end else if (clk_en) begin
      q_r <= q_nxt;
    end
  end
endmodule : hwcfg_word

// ==== verilog/hwcfg_bank.sv ====
// hardware configuration register bank with brake and speed source decode
`timescale 1ns/1ns
module hwcfg_bank #(
  parameter int unsigned ANGLE_W = 16
) (
  input  wire logic               ref_clk,
  input  wire logic               rst_b,
  input  wire logic               clk_en,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  input  wire logic [7:0]         reg_addr,
  input  wire logic [31:0]        reg_wdata,
  output logic [31:0]             reg_rdata_r,
  output logic                    reg_err_r,
  input  wire logic [31:0]        dev1_strap,
  input  wire logic               brake_pin,
  input  wire logic [ANGLE_W-1:0] comm_angle,
  input  wire logic [ANGLE_W-1:0] align_angle_cfg,
  output logic [1:0]              speed_src_r,
  output logic                    brake_active_r,
  output logic                    low_side_on_r,
  output logic                    align_brake_r,
  output logic [ANGLE_W-1:0]      align_angle_r,
  output logic [1:0]              max_bus_voltage_sel_r,
  output logic                    bus_voltage_undef_r,
  output logic [31:0]             hw_pin_setup_r,
  output logic [31:0]             device_setup_one_r,
  output logic [31:0]             device_setup_two_r,
  output logic [31:0]             peripheral_setup_one_r,
  output logic [31:0]             gate_drive_setup_one_r,
  output logic [31:0]             gate_drive_setup_two_r
);
  logic [31:0] regs [0:5];
  logic [5:0]  hit;
  logic [5:0]  wen;
  logic        strap_pending_r;
  logic        strap_load;
  hwcfg_pkg::hwcfg_brake_t state_r;
  hwcfg_pkg::hwcfg_brake_t state_nxt;

  // address decode; unlisted offsets match nothing and are ignored on write
  assign hit[0] = (reg_addr == hwcfg_pkg::OFF_HW_PIN_SETUP);
  assign hit[1] = (reg_addr == hwcfg_pkg::OFF_DEVICE_SETUP_ONE);
  assign hit[2] = (reg_addr == hwcfg_pkg::OFF_DEVICE_SETUP_TWO);
  assign hit[3] = (reg_addr == hwcfg_pkg::OFF_PERIPHERAL_SETUP_ONE);
  assign hit[4] = (reg_addr == hwcfg_pkg::OFF_GATE_DRIVE_SETUP_ONE);
  assign hit[5] = (reg_addr == hwcfg_pkg::OFF_GATE_DRIVE_SETUP_TWO);
  assign wen    = reg_wr ? hit : 6'h00;
  wire   miss   = (hit == 6'h00);

  // strap load one cycle after reset release
  assign strap_load = strap_pending_r;
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      strap_pending_r <= 1'b1;
    end else if (clk_en) begin
      strap_pending_r <= 1'b0;
    end
  end

  // the six words; full 32 bits kept so parity and reserved bits read back
  hwcfg_word #(.RST_MASK(32'hFFFFFFFF), .RST_VAL(hwcfg_pkg::RST_HW_PIN_SETUP)) u_pin (
    .ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en), .wr_en(wen[0]),
    .wr_data(reg_wdata), .strap_load(1'b0), .strap_val(32'h00000000), .q_r(regs[0]));
  hwcfg_word #(.RST_MASK(hwcfg_pkg::DEV1_ZERO_MASK), .RST_VAL(hwcfg_pkg::RST_OTHER)) u_dev1 (
    .ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en), .wr_en(wen[1]),
    .wr_data(reg_wdata), .strap_load(strap_load), .strap_val(dev1_strap), .q_r(regs[1]));
  hwcfg_word #(.RST_MASK(32'hFFFFFFFF), .RST_VAL(hwcfg_pkg::RST_DEVICE_SETUP_TWO)) u_dev2 (
    .ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en), .wr_en(wen[2]),
    .wr_data(reg_wdata), .strap_load(1'b0), .strap_val(32'h00000000), .q_r(regs[2]));
  // remaining words: layout owned elsewhere, stored verbatim
  genvar gi;
  generate
    for (gi = 3; gi < 6; gi = gi + 1) begin : g_rest
      hwcfg_word #(.RST_MASK(32'hFFFFFFFF), .RST_VAL(hwcfg_pkg::RST_OTHER)) u_w (
        .ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en), .wr_en(wen[gi]),
        .wr_data(reg_wdata), .strap_load(1'b0), .strap_val(32'h00000000), .q_r(regs[gi]));
    end
  endgenerate

  // field extraction
  wire [1:0] speed_f = regs[0][hwcfg_pkg::PIN_SPEED_LSB +: 2];
  wire [1:0] brk_f   = regs[0][hwcfg_pkg::PIN_BRAKE_LSB +: 2];
  wire       angle_f = regs[0][hwcfg_pkg::PIN_ANGLE_BIT];
  wire       style_f = regs[0][hwcfg_pkg::PIN_STYLE_BIT];
  wire [1:0] busv_f  = regs[1][hwcfg_pkg::BUSV_LSB +: 2];

  // brake request: override codes beat the pin, 0h and 3h follow it
  wire brake_req = (brk_f == hwcfg_pkg::BRK_FORCE_ON)  ? 1'b1 :
                   (brk_f == hwcfg_pkg::BRK_FORCE_OFF) ? 1'b0 :
                   brake_pin;

  // read mux; unmapped reads return zero
  wire [31:0] rd_mux = hit[0] ? regs[0] : hit[1] ? regs[1] : hit[2] ? regs[2] :
                       hit[3] ? regs[3] : hit[4] ? regs[4] : hit[5] ? regs[5] : 32'h00000000;

  // brake sequencer: style chosen at brake entry, applies to override and pin
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      hwcfg_pkg::HWCFG_RUN: begin
        if (brake_req) begin
          state_nxt = style_f ? hwcfg_pkg::HWCFG_ALIGN : hwcfg_pkg::HWCFG_LOW_BRAKE;
        end
      end
      hwcfg_pkg::HWCFG_LOW_BRAKE,
      hwcfg_pkg::HWCFG_ALIGN: begin
        if (!brake_req) begin
          state_nxt = hwcfg_pkg::HWCFG_RUN;
        end
      end
      default: state_nxt = hwcfg_pkg::HWCFG_RUN;
    endcase
  end

  // angle: with the angle bit clear the last commutation angle is frozen on brake entry; with it set align_angle_cfg is taken
  wire entering = (state_r == hwcfg_pkg::HWCFG_RUN) && brake_req;
  wire [ANGLE_W-1:0] angle_nxt = angle_f ? align_angle_cfg :
                                 (entering ? comm_angle : align_angle_r);

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      state_r       <= hwcfg_pkg::HWCFG_RUN;
      align_angle_r <= '0;
    end else if (clk_en) begin
      state_r       <= state_nxt;
      align_angle_r <= angle_nxt;
    end
  end

  // registered outputs
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      reg_rdata_r            <= 32'h00000000;
      reg_err_r              <= 1'b0;
      speed_src_r            <= hwcfg_pkg::SPD_ANALOG;
      brake_active_r         <= 1'b0;
      low_side_on_r          <= 1'b0;
      align_brake_r          <= 1'b0;
      max_bus_voltage_sel_r  <= hwcfg_pkg::BUSV_15;
      bus_voltage_undef_r    <= 1'b0;
    end else if (clk_en) begin
      reg_rdata_r            <= reg_rd ? rd_mux : reg_rdata_r;
      reg_err_r              <= (reg_rd | reg_wr) & miss;
      speed_src_r            <= speed_f;
      brake_active_r         <= (state_nxt != hwcfg_pkg::HWCFG_RUN);
      low_side_on_r          <= (state_nxt == hwcfg_pkg::HWCFG_LOW_BRAKE);
      align_brake_r          <= (state_nxt == hwcfg_pkg::HWCFG_ALIGN);
      max_bus_voltage_sel_r  <= busv_f;
      bus_voltage_undef_r    <= (busv_f == 2'h3);
    end
  end

  // register images for the rest of the device
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      hw_pin_setup_r         <= hwcfg_pkg::RST_HW_PIN_SETUP;
      device_setup_one_r     <= hwcfg_pkg::RST_OTHER;
      device_setup_two_r     <= hwcfg_pkg::RST_DEVICE_SETUP_TWO;
      peripheral_setup_one_r <= hwcfg_pkg::RST_OTHER;
      gate_drive_setup_one_r <= hwcfg_pkg::RST_OTHER;
      gate_drive_setup_two_r <= hwcfg_pkg::RST_OTHER;
    end else if (clk_en) begin
      hw_pin_setup_r         <= regs[0];
      device_setup_one_r     <= regs[1];
      device_setup_two_r     <= regs[2];
      peripheral_setup_one_r <= regs[3];
      gate_drive_setup_one_r <= regs[4];
      gate_drive_setup_two_r <= regs[5];
    end
  end
endmodule : hwcfg_bank

// ==== testbench/hwcfg_bank_checker.sv ====
// port assertions for the hardware configuration bank
`timescale 1ns/1ns
module hwcfg_bank_checker (
  input wire logic        ref_clk,
  input wire logic        rst_b,
  input wire logic        clk_en,
  input wire logic        reg_rd,
  input wire logic        reg_wr,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_rdata_r,
  input wire logic        reg_err_r,
  input wire logic [1:0]  speed_src_r,
  input wire logic        brake_active_r,
  input wire logic        low_side_on_r,
  input wire logic        align_brake_r,
  input wire logic [1:0]  max_bus_voltage_sel_r,
  input wire logic        bus_voltage_undef_r,
  input wire logic [31:0] hw_pin_setup_r,
  input wire logic [31:0] device_setup_one_r
);
  // decode of the six word offsets; odd offsets alias nothing
  wire mapped = reg_addr >= 8'hA4 && reg_addr <= 8'hAE && !reg_addr[0];
  wire rd_go  = clk_en && reg_rd;
  // unmapped writes raise the error flag as well
  wire acc_go = clk_en && (reg_rd || reg_wr);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  chk_err_unmapped: assert property (rd_go && !mapped |=> reg_err_r && reg_rdata_r == 32'h0)
    else $error("unmapped read not refused");
  chk_err_quiet: assert property (!(acc_go && !mapped) |=> !reg_err_r)
    else $error("error flag without unmapped access");
  chk_err_write: assert property (clk_en && reg_wr && !mapped |=> reg_err_r)
    else $error("unmapped write not flagged");
  chk_rd_pin: assert property (rd_go && reg_addr == 8'hA4 |=> reg_rdata_r == hw_pin_setup_r)
    else $error("pin setup read differs from store");
  chk_rdata_hold: assert property (!rd_go |=> $stable(reg_rdata_r))
    else $error("read data moved without a read");
  chk_speed_follow: assert property (speed_src_r == hw_pin_setup_r[1:0])
    else $error("speed source differs from field");
  chk_busv_follow: assert property (max_bus_voltage_sel_r == device_setup_one_r[1:0] &&
    bus_voltage_undef_r == (device_setup_one_r[1:0] == 2'h3))
    else $error("bus voltage outputs differ from field");
  chk_force_off: assert property ((hw_pin_setup_r[3:2] == 2'h2) [*2] |-> !brake_active_r)
    else $error("braking while suppressed");
  chk_force_on: assert property ((hw_pin_setup_r[3:2] == 2'h1) [*2] |-> brake_active_r)
    else $error("no braking while forced");
  chk_brake_kind: assert property (brake_active_r == (low_side_on_r ^ align_brake_r))
    else $error("brake kind not exactly one");
endmodule : hwcfg_bank_checker
bind hwcfg_bank hwcfg_bank_checker hwcfg_bank_checker_i (.ref_clk(ref_clk), .rst_b(rst_b),
  .clk_en(clk_en), .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_addr(reg_addr),
  .reg_rdata_r(reg_rdata_r),
  .reg_err_r(reg_err_r), .speed_src_r(speed_src_r), .brake_active_r(brake_active_r),
  .low_side_on_r(low_side_on_r), .align_brake_r(align_brake_r),
  .max_bus_voltage_sel_r(max_bus_voltage_sel_r), .bus_voltage_undef_r(bus_voltage_undef_r),
  .hw_pin_setup_r(hw_pin_setup_r), .device_setup_one_r(device_setup_one_r));

// ==== testbench/test_hwcfg_bank.sv ====
// self-checking bench for the hardware configuration bank
`timescale 1ns/1ns
module test_hwcfg_bank;
  logic        ref_clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        clk_en = 1'b1;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        brake_pin = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic [15:0] comm_angle = 16'h0;
  logic [15:0] align_angle_cfg = 16'h0;
  logic [31:0] reg_rdata_r, hw_pin_setup_r;
  logic [31:0] device_setup_one_r, device_setup_two_r, peripheral_setup_one_r;
  logic [31:0] gate_drive_setup_one_r, gate_drive_setup_two_r;
  logic [15:0] align_angle_r;
  logic [1:0]  speed_src_r, max_bus_voltage_sel_r;
  logic        reg_err_r, brake_active_r, low_side_on_r, align_brake_r, bus_voltage_undef_r;
  int          error_cnt = 0;
  int          n_compared = 0;
  hwcfg_bank #(.ANGLE_W(16)) hwcfg_bank_i (.ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata_r(reg_rdata_r), .reg_err_r(reg_err_r), .dev1_strap(32'hFFFFFFFF),
    .brake_pin(brake_pin), .comm_angle(comm_angle), .align_angle_cfg(align_angle_cfg),
    .speed_src_r(speed_src_r), .brake_active_r(brake_active_r), .low_side_on_r(low_side_on_r),
    .align_brake_r(align_brake_r), .align_angle_r(align_angle_r),
    .max_bus_voltage_sel_r(max_bus_voltage_sel_r), .bus_voltage_undef_r(bus_voltage_undef_r),
    .hw_pin_setup_r(hw_pin_setup_r), .device_setup_one_r(device_setup_one_r),
    .device_setup_two_r(device_setup_two_r), .peripheral_setup_one_r(peripheral_setup_one_r),
    .gate_drive_setup_one_r(gate_drive_setup_one_r),
    .gate_drive_setup_two_r(gate_drive_setup_two_r));
  // 25 MHz clock
  always #20 ref_clk = ~ref_clk;
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // every access leaves one idle edge so a strobe is never re-driven in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge ref_clk) #2 reg_wr = 1'b0;
    @(posedge ref_clk) #2;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic err);
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge ref_clk) #2 reg_rd = 1'b0;
    chk("reg_rdata_r", reg_rdata_r, exp);
    chk("reg_err_r", {31'h0, reg_err_r}, {31'h0, err});
    @(posedge ref_clk) #2;
  endtask : rd
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk);
    #2;
  endtask : idle
  task automatic t_reset;
    rd(8'hA4, 32'h0, 1'b0);
    rd(8'hA6, 32'h07FFFFE0, 1'b0);
    rd(8'hA8, 32'h0, 1'b0);
  endtask : t_reset
  // parity and reserved bits must survive a round trip
  task automatic t_rw;
    for (int i = 0; i < 6; i++) wr(8'hA4 + 8'(2 * i), 32'hA5C30F00 ^ 32'(i));
    for (int i = 0; i < 6; i++) rd(8'hA4 + 8'(2 * i), 32'hA5C30F00 ^ 32'(i), 1'b0);
    chk("hw_pin_setup_r", hw_pin_setup_r, 32'hA5C30F00);
    chk("device_setup_one_r", device_setup_one_r, 32'hA5C30F01);
    chk("device_setup_two_r", device_setup_two_r, 32'hA5C30F02);
    chk("peripheral_setup_one_r", peripheral_setup_one_r, 32'hA5C30F03);
    chk("gate_drive_setup_one_r", gate_drive_setup_one_r, 32'hA5C30F04);
    chk("gate_drive_setup_two_r", gate_drive_setup_two_r, 32'hA5C30F05);
  endtask : t_rw
  // odd offsets catch a decoder that drops bit 0; frozen enable must drop writes
  task automatic t_unmapped;
    wr(8'hA5, 32'hFFFFFFFF);
    wr(8'hB0, 32'hFFFFFFFF);
    rd(8'hA5, 32'h0, 1'b1);
    rd(8'hA2, 32'h0, 1'b1);
    clk_en = 1'b0;
    wr(8'hA4, 32'h3);
    clk_en = 1'b1;
    rd(8'hA4, 32'hA5C30F00, 1'b0);
  endtask : t_unmapped
  task automatic t_codes;
    for (int c = 0; c < 4; c++) begin
      wr(8'hA4, 32'(c) | 32'h8);
      wr(8'hA6, 32'(c));
      idle(1);
      chk("speed_src_r", {30'h0, speed_src_r}, 32'(c));
      chk("max_bus_voltage_sel_r", {30'h0, max_bus_voltage_sel_r}, 32'(c));
      chk("bus_voltage_undef_r", {31'h0, bus_voltage_undef_r}, {31'h0, c == 3});
    end
  endtask : t_codes
  // table entries are override code, pin level, expected braking
  task automatic t_brake;
    logic [3:0] tbl [6] = '{4'h3, 4'h0, 4'hF, 4'hC, 4'h5, 4'hA};
    foreach (tbl[k]) begin
      brake_pin = tbl[k][1];
      wr(8'hA4, {28'h0, tbl[k][3:2], 2'h0});
      idle(2);
      chk("brake_active_r", {31'h0, brake_active_r}, {31'h0, tbl[k][0]});
      chk("low_side_on_r", {31'h0, low_side_on_r}, {31'h0, tbl[k][0]});
    end
  endtask : t_brake
  task automatic t_angle;
    comm_angle = 16'h1234;
    align_angle_cfg = 16'hBEEF;
    wr(8'hA4, 32'h24);
    idle(2);
    comm_angle = 16'h5678;
    idle(2);
    chk("align_brake_r", {31'h0, align_brake_r}, 32'h1);
    chk("low_side_on_r", {31'h0, low_side_on_r}, 32'h0);
    chk("align_angle_r", {16'h0, align_angle_r}, 32'h1234);
    wr(8'hA4, 32'h28);
    wr(8'hA4, 32'h34);
    idle(2);
    chk("align_angle_r", {16'h0, align_angle_r}, 32'hBEEF);
  endtask : t_angle
  // mid-run reset with the pin high: pin control and low-side braking must come back
  task automatic t_rerst;
    brake_pin = 1'b1;
    rst_b = 1'b0;
    idle(2);
    chk("brake_active_r", {31'h0, brake_active_r}, 32'h0);
    rst_b = 1'b1;
    idle(2);
    chk("hw_pin_setup_r", hw_pin_setup_r, 32'h0);
    chk("device_setup_two_r", device_setup_two_r, 32'h0);
    chk("low_side_on_r", {31'h0, low_side_on_r}, 32'h1);
    chk("align_brake_r", {31'h0, align_brake_r}, 32'h0);
    t_reset();
  endtask : t_rerst
  task automatic conclude;
    if (error_cnt == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : conclude
  // watchdog well beyond the roughly 130 cycles the run needs
  initial begin
    #100000;
    error_cnt++;
    conclude();
  end
  // main sequence
  initial begin
    repeat (16) @(posedge ref_clk);
    #2 rst_b = 1'b1;
    idle(2);
    t_reset();
    t_rw();
    t_unmapped();
    t_codes();
    t_brake();
    t_angle();
    t_rerst();
    conclude();
  end
endmodule : test_hwcfg_bank
